// [hdl/peripheral_signal_routing_regs.vh]
// Register indices, field layout and reset values of the signal routing block
`ifndef PERIPHERAL_SIGNAL_ROUTING_REGS_VH
`define PERIPHERAL_SIGNAL_ROUTING_REGS_VH
// Register indices; byte address is four times the index
`define IDX_PWM_ROUTE   10'h201
`define IDX_TMR_ROUTE   10'h202
`define IDX_ADC_ROUTE   10'h203
`define IDX_CAP_SEL     10'h204
`define IDX_CLK_OUT     10'h205
`define IDX_IRQ_CTRL    10'h206
`define IDX_TEST        10'h208
// Implemented bits of each register
`define MASK_PWM        8'hF5
`define MASK_TMR        8'hFC
`define MASK_ADC        8'h0F
`define MASK_CAP        8'h03
`define MASK_CLK_OUT    8'h80
`define MASK_IRQ        8'hC0
`define MASK_TEST       8'hFF
// Field positions
`define BIT_CMP_TRIG    3
`define BIT_TRIG_NEG    2
`define BIT_CLK_DIS     7
`define BIT_IRQ_EDGE    7
`define BIT_IRQ_CONN    6
// Reset values
`define RST_ROUTE       8'h00
`define RST_CLK_OUT     8'h00
`define RST_IRQ         8'h00
`define RST_TEST        8'h00
// Trigger and capture source codes
`define SRC_PIN_P6      2'h3
`define SRC_PAD5        2'h2
`define SRC_PIN_E0      2'h1
`define SRC_AUX_CLK     2'h3
`define SRC_SERIAL1     2'h2
`define SRC_SERIAL0     2'h1
// Synchroniser vector layout
`define SY_PP           0
`define SY_PS           8
`define SY_PT           12
`define SY_PAD5         20
`define SY_PE0          21
`define SY_CMP          22
`define SY_ACLK         23
`define SY_IRQ          24
`define SY_WIDTH        25
`endif

// [hdl/peripheral_signal_routing.v]
// Peripheral signal routing: pin mux, trigger and capture select, clock out, irq sense
//
// How it works
// - Routing registers always readable; normal mode takes first write only, special every.
// - PWM 7 on port J pin 1 when its bit set, else port P pin 7.
// - PWM 6 on port S pin 1 when its bit set, else port P pin 6.
// - PWM 5 on port J pin 0 when its bit set, else port P pin 5.
// - PWM 4 on port S pin 0 when its bit set, else port P pin 4.
// - PWM 2 on port T pin 0 when its bit set, else port P pin 2.
// - PWM 0 on port T pin 1 when its bit set, else port P pin 0.
// - Timer 1 channels 1 and 0 move to port P pins 1 and 7.
// - Timer 0 channels 5 and 4 move to port S pins 3 and 2.
// - Timer 0 channels 3 and 2 move to port S pins 1 and 0.
// - Comparator bit set feeds comparator to ADC trigger, else source field decides.
// - Polarity bit set makes falling edges active on ADC trigger, else rising.
// - Source field: 11 P6, 10 pad 5, 01 E0, 00 timer 0 compare 2.
// - Comparator bit exists only when the build option enables it.
// - Capture 3 source: 11 aux clock, 10 serial 1, 01 serial 0, 00 pin.
// - Clock output control is readable and writable at any time.
// - Edge mode latches falling edges until reset or service; else low level recognised.
// - Edge select writable once in normal mode; pin connect bit writable anytime.
// - Connect bit clear disconnects the interrupt pin; no request is raised.
// - Factory test register readable always, writable only in special mode.
// - Unimplemented bits ignore writes and read as zero.
`timescale 1ns/1ps
`include "peripheral_signal_routing_regs.vh"
module peripheral_signal_routing #(
  parameter HAS_CMP_TRIG = 1
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        special_mode,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire [7:0]  pwm_out,
  input  wire [5:2]  timer0_oc,
  input  wire [5:2]  timer0_oe,
  input  wire [1:0]  tim1_oc,
  input  wire [1:0]  tim1_oe,
  input  wire [7:0]  pp_in,
  input  wire [3:0]  ps_in,
  input  wire [7:0]  pt_in,
  input  wire        pad5_in,
  input  wire        pe0_in,
  input  wire        cmp_in,
  input  wire        aclk_in,
  input  wire        irq_pin,
  input  wire        serial0_receive,
  input  wire        serial1_receive,
  input  wire        irq_service,
  output reg  [7:0]  pp_out,
  output reg  [7:0]  pp_claim,
  output reg  [1:0]  pj_out,
  output reg  [1:0]  pj_claim,
  output reg  [3:0]  ps_out,
  output reg  [3:0]  ps_claim,
  output reg  [7:0]  pt_out,
  output reg  [7:0]  pt_claim,
  output reg  [5:2]  timer0_ic,
  output reg  [1:0]  tim1_ic,
  output reg         adc_trigger,
  output reg         bus_clock_output_en,
  output reg         irq_request
);

  reg  [7:0]  pwm_route_ctrl_reg;
  reg  [7:0]  timer_channel_route_ctrl_reg;
  reg  [7:0]  adc_trigger_route_ctrl_reg;
  reg  [7:0]  capture_source_select_reg;
  reg  [7:0]  bus_clock_output_ctrl_reg;
  reg  [7:0]  external_interrupt_ctrl_reg;
  reg  [7:0]  factory_test_reg;
  reg  [4:0]  lock_reg;
  reg         ph_act_reg;
  reg         ph_wr_reg;
  reg  [9:0]  ph_idx_reg;
  reg         edge_latch_reg;
  reg         irq_prev_reg;

  wire [`SY_WIDTH-1:0] async_in;
  reg  [`SY_WIDTH-1:0] sy1_reg;
  reg  [`SY_WIDTH-1:0] sy2_reg;
  reg  [`SY_WIDTH-1:0] sy3_reg;
  reg  [`SY_WIDTH-1:0] st_reg;

  reg  [7:0]  rd_next;
  reg  [7:0]  pp_next;
  reg  [7:0]  ppc_next;
  reg  [1:0]  pj_next;
  reg  [1:0]  pjc_next;
  reg  [3:0]  ps_next;
  reg  [3:0]  psc_next;
  reg  [7:0]  pt_next;
  reg  [7:0]  ptc_next;
  reg  [5:2]  ic0_next;
  reg  [1:0]  ic1_next;
  reg         trig_src;
  reg         cap3_next;
  integer     n;

  wire [7:0]  wd = hwdata[7:0];
  wire        take = hsel & htrans[1] & hready;
  wire        do_wr = ph_act_reg & ph_wr_reg;
  wire [7:0]  adc_mask = HAS_CMP_TRIG ? `MASK_ADC : (`MASK_ADC & 8'hF7);
  wire        edge_mode = external_interrupt_ctrl_reg[`BIT_IRQ_EDGE];
  wire        irq_fall = irq_prev_reg & ~st_reg[`SY_IRQ];

  assign async_in = {irq_pin, aclk_in, cmp_in, pe0_in, pad5_in, pt_in, ps_in, pp_in};

  // Three stages; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `SY_WIDTH; g = g + 1) begin : sync
      always @(posedge ref_clk) begin
        if (rst) begin
          sy1_reg[g] <= 1'b0;
          sy2_reg[g] <= 1'b0;
          sy3_reg[g] <= 1'b0;
          st_reg[g]  <= 1'b0;
        end else if (ce) begin
          sy1_reg[g] <= async_in[g];
          sy2_reg[g] <= sy1_reg[g];
          sy3_reg[g] <= sy2_reg[g];
          if (sy2_reg[g] == sy3_reg[g]) begin
            st_reg[g] <= sy3_reg[g];
          end
        end
      end
    end
  endgenerate

  // Read value; unimplemented bits and unmapped indices read zero
  always @* begin
    case (ph_idx_reg)
      `IDX_PWM_ROUTE: rd_next = pwm_route_ctrl_reg;
      `IDX_TMR_ROUTE: rd_next = timer_channel_route_ctrl_reg;
      `IDX_ADC_ROUTE: rd_next = adc_trigger_route_ctrl_reg;
      `IDX_CAP_SEL:   rd_next = capture_source_select_reg;
      `IDX_CLK_OUT:   rd_next = bus_clock_output_ctrl_reg;
      `IDX_IRQ_CTRL:  rd_next = external_interrupt_ctrl_reg;
      `IDX_TEST:      rd_next = factory_test_reg;
      default:        rd_next = 8'h00;
    endcase
  end

  // Bus slave: one wait state so read data comes from a flop
  // Size is ignored; each register sits in the low byte of its word
  always @(posedge ref_clk) begin
    if (rst) begin
      ph_act_reg <= 1'b0;
      ph_wr_reg  <= 1'b0;
      ph_idx_reg <= 10'h000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
    end else if (ce) begin
      hresp <= 1'b0;
      if (ph_act_reg) begin
        ph_act_reg <= 1'b0;
        hreadyout  <= 1'b1;
        hrdata     <= {24'h00_0000, rd_next};
      end else if (take) begin
        ph_act_reg <= 1'b1;
        ph_wr_reg  <= hwrite;
        ph_idx_reg <= haddr[11:2];
        hreadyout  <= 1'b0;
      end
    end
  end

  // Register writes with write-once locks
  always @(posedge ref_clk) begin
    if (rst) begin
      pwm_route_ctrl_reg           <= `RST_ROUTE;
      timer_channel_route_ctrl_reg <= `RST_ROUTE;
      adc_trigger_route_ctrl_reg   <= `RST_ROUTE;
      capture_source_select_reg    <= `RST_ROUTE;
      bus_clock_output_ctrl_reg    <= `RST_CLK_OUT;
      external_interrupt_ctrl_reg  <= `RST_IRQ;
      factory_test_reg             <= `RST_TEST;
      lock_reg                     <= 5'h00;
    end else if (ce && do_wr) begin
      case (ph_idx_reg)
        `IDX_PWM_ROUTE: begin
          if (special_mode || !lock_reg[0]) begin
            pwm_route_ctrl_reg <= wd & `MASK_PWM;
            lock_reg[0]        <= lock_reg[0] | ~special_mode;
          end
        end
        `IDX_TMR_ROUTE: begin
          if (special_mode || !lock_reg[1]) begin
            timer_channel_route_ctrl_reg <= wd & `MASK_TMR;
            lock_reg[1]                  <= lock_reg[1] | ~special_mode;
          end
        end
        `IDX_ADC_ROUTE: begin
          if (special_mode || !lock_reg[2]) begin
            adc_trigger_route_ctrl_reg <= wd & adc_mask;
            lock_reg[2]                <= lock_reg[2] | ~special_mode;
          end
        end
        `IDX_CAP_SEL: begin
          if (special_mode || !lock_reg[3]) begin
            capture_source_select_reg <= wd & `MASK_CAP;
            lock_reg[3]               <= lock_reg[3] | ~special_mode;
          end
        end
        `IDX_CLK_OUT: begin
          bus_clock_output_ctrl_reg <= wd & `MASK_CLK_OUT;
        end
        `IDX_IRQ_CTRL: begin
          // Connect bit always; edge bit only while unlocked or special
          external_interrupt_ctrl_reg[`BIT_IRQ_CONN] <= wd[`BIT_IRQ_CONN];
          if (special_mode || !lock_reg[4]) begin
            external_interrupt_ctrl_reg[`BIT_IRQ_EDGE] <= wd[`BIT_IRQ_EDGE];
            lock_reg[4] <= lock_reg[4] | ~special_mode;
          end
        end
        `IDX_TEST: begin
          if (special_mode) begin
            factory_test_reg <= wd & `MASK_TEST;
          end
        end
        default: begin
          lock_reg <= lock_reg;
        end
      endcase
    end
  end

  // Pin mux; a timer with its output enable set takes a shared pin over PWM when both select it
  always @* begin
    pp_next  = pwm_out;
    ppc_next = ~(pwm_route_ctrl_reg & `MASK_PWM);
    pj_next  = {pwm_out[7], pwm_out[5]};
    pjc_next = {pwm_route_ctrl_reg[7], pwm_route_ctrl_reg[5]};
    ps_next  = {2'b00, pwm_out[6], pwm_out[4]};
    psc_next = {2'b00, pwm_route_ctrl_reg[6], pwm_route_ctrl_reg[4]};
    pt_next  = {6'h00, pwm_out[0], pwm_out[2]};
    ptc_next = {6'h00, pwm_route_ctrl_reg[0], pwm_route_ctrl_reg[2]};
    // Timer input follows the selected pin whether or not the output drives it
    for (n = 2; n < 6; n = n + 1) begin
      if (timer_channel_route_ctrl_reg[n]) begin
        if (timer0_oe[n]) begin
          ps_next[n-2]  = timer0_oc[n];
          psc_next[n-2] = 1'b1;
        end
        ic0_next[n] = st_reg[`SY_PS+n-2];
      end else begin
        if (timer0_oe[n]) begin
          pt_next[n]  = timer0_oc[n];
          ptc_next[n] = 1'b1;
        end
        ic0_next[n] = st_reg[`SY_PT+n];
      end
    end
    if (timer_channel_route_ctrl_reg[6]) begin
      if (tim1_oe[0]) begin
        pp_next[7]  = tim1_oc[0];
        ppc_next[7] = 1'b1;
      end
      ic1_next[0] = st_reg[`SY_PP+7];
    end else begin
      if (tim1_oe[0]) begin
        pt_next[6]  = tim1_oc[0];
        ptc_next[6] = 1'b1;
      end
      ic1_next[0] = st_reg[`SY_PT+6];
    end
    if (timer_channel_route_ctrl_reg[7]) begin
      if (tim1_oe[1]) begin
        pp_next[1]  = tim1_oc[1];
        ppc_next[1] = 1'b1;
      end
      ic1_next[1] = st_reg[`SY_PP+1];
    end else begin
      if (tim1_oe[1]) begin
        pt_next[7]  = tim1_oc[1];
        ptc_next[7] = 1'b1;
      end
      ic1_next[1] = st_reg[`SY_PT+7];
    end
    // Capture channel 3 source
    case (capture_source_select_reg[1:0])
      `SRC_AUX_CLK: cap3_next = st_reg[`SY_ACLK];
      `SRC_SERIAL1: cap3_next = serial1_receive;
      `SRC_SERIAL0: cap3_next = serial0_receive;
      default:      cap3_next = ic0_next[3];
    endcase
    // ADC trigger source
    case (adc_trigger_route_ctrl_reg[1:0])
      `SRC_PIN_P6: trig_src = st_reg[`SY_PP+6];
      `SRC_PAD5:   trig_src = st_reg[`SY_PAD5];
      `SRC_PIN_E0: trig_src = st_reg[`SY_PE0];
      default:     trig_src = timer0_oc[2];
    endcase
    if (HAS_CMP_TRIG != 0 && adc_trigger_route_ctrl_reg[`BIT_CMP_TRIG]) begin
      trig_src = st_reg[`SY_CMP];
    end
  end

  // Registered pin side; costs one cycle of latency on every path
  always @(posedge ref_clk) begin
    if (rst) begin
      pp_out              <= 8'h00;
      pp_claim            <= 8'h00;
      pj_out              <= 2'b00;
      pj_claim            <= 2'b00;
      ps_out              <= 4'h0;
      ps_claim            <= 4'h0;
      pt_out              <= 8'h00;
      pt_claim            <= 8'h00;
      timer0_ic           <= 4'h0;
      tim1_ic             <= 2'b00;
      adc_trigger         <= 1'b0;
      bus_clock_output_en <= 1'b0;
    end else if (ce) begin
      pp_out              <= pp_next;
      pp_claim            <= ppc_next;
      pj_out              <= pj_next;
      pj_claim            <= pjc_next;
      ps_out              <= ps_next;
      ps_claim            <= psc_next;
      pt_out              <= pt_next;
      pt_claim            <= ptc_next;
      timer0_ic           <= {ic0_next[5:4], cap3_next, ic0_next[2]};
      tim1_ic             <= ic1_next;
      // Inverted source makes a falling pin edge a rising trigger edge
      adc_trigger         <= trig_src ^ adc_trigger_route_ctrl_reg[`BIT_TRIG_NEG];
      // Gates the pad's bus clock; a flop cannot toggle at the bus rate
      bus_clock_output_en <= ~bus_clock_output_ctrl_reg[`BIT_CLK_DIS];
    end
  end

  // External interrupt sensing
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_prev_reg   <= 1'b0;
      edge_latch_reg <= 1'b0;
      irq_request    <= 1'b0;
    end else if (ce) begin
      irq_prev_reg <= st_reg[`SY_IRQ];
      // Set wins over a service clear in the same cycle
      if (edge_mode && irq_fall) begin
        edge_latch_reg <= 1'b1;
      end else if (irq_service) begin
        edge_latch_reg <= 1'b0;
      end
      // Latch runs while disconnected; reconnecting then raises the request
      if (!external_interrupt_ctrl_reg[`BIT_IRQ_CONN]) begin
        irq_request <= 1'b0;
      end else if (edge_mode) begin
        irq_request <= edge_latch_reg | irq_fall;
      end else begin
        irq_request <= ~st_reg[`SY_IRQ];
      end
    end
  end

endmodule

// [dv/peripheral_signal_routing_assertions.sv]
// Port-level checks of the signal routing block
`timescale 1ns/1ps
module peripheral_signal_routing_assertions (
  input wire        ref_clk,
  input wire        rst,
  input wire        ce,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire [7:0]  pwm_out,
  input wire [5:2]  timer0_oc,
  input wire [5:2]  timer0_oe,
  input wire [7:0]  pp_out,
  input wire [7:0]  pp_claim,
  input wire [1:0]  pj_out,
  input wire [1:0]  pj_claim,
  input wire [3:0]  ps_out,
  input wire [3:0]  ps_claim,
  input wire [7:0]  pt_out,
  input wire [7:0]  pt_claim,
  input wire        adc_trigger,
  input wire        bus_clock_output_en,
  input wire        irq_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_bus_one_wait: assert property (ce && hsel && htrans[1] && hready
    |=> !hreadyout ##1 hreadyout) else $error("bus wait state wrong");
  chk_resp_okay: assert property (!hresp && hrdata[31:8] == 24'h0)
    else $error("bus response or upper data wrong");
  chk_pwm7_alt: assert property (pj_claim[1] |-> pj_out[1] == $past(pwm_out[7]))
    else $error("pwm 7 alternate pin wrong");
  chk_pwm5_alt: assert property (pj_claim[0] |-> pj_out[0] == $past(pwm_out[5]))
    else $error("pwm 5 alternate pin wrong");
  chk_pwm2_alt: assert property (pt_claim[0] |-> pt_out[0] == $past(pwm_out[2]))
    else $error("pwm 2 alternate pin wrong");
  chk_pwm0_alt: assert property (pt_claim[1] |-> pt_out[1] == $past(pwm_out[0]))
    else $error("pwm 0 alternate pin wrong");
  chk_tmr_ch5_alt: assert property (ps_claim[3] |->
    ps_out[3] == $past(timer0_oc[5]) && $past(timer0_oe[5])) else $error("timer 5 pin wrong");
  // Pin 3 of port P has no alternate owner, so it is held once reset is over
  chk_pp3_default: assert property (!$past(rst) |->
    pp_claim[3] && pp_out[3] == $past(pwm_out[3])) else $error("default pin 3 wrong");
  chk_reset_idle: assert property ($fell(rst) |-> hreadyout && !irq_request
    && !adc_trigger && !bus_clock_output_en && pp_claim == 8'h00)
    else $error("outputs not idle after reset");
endmodule
bind peripheral_signal_routing peripheral_signal_routing_assertions i_chk (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_out(pwm_out),
  .timer0_oc(timer0_oc), .timer0_oe(timer0_oe), .pp_out(pp_out), .pp_claim(pp_claim),
  .pj_out(pj_out), .pj_claim(pj_claim), .ps_out(ps_out), .ps_claim(ps_claim),
  .pt_out(pt_out), .pt_claim(pt_claim), .adc_trigger(adc_trigger),
  .bus_clock_output_en(bus_clock_output_en), .irq_request(irq_request));

// [dv/periph_pin_model.sv]
// Peripheral and pin side model: one stimulus vector fanned out to the block
`timescale 1ns/1ps
module periph_pin_model (
  input  wire [46:0] cfg,
  output wire [7:0]  pwm_out,
  output wire [5:2]  timer0_oc,
  output wire [5:2]  timer0_oe,
  output wire [1:0]  tim1_oc,
  output wire [1:0]  tim1_oe,
  output wire [7:0]  pp_in,
  output wire [3:0]  ps_in,
  output wire [7:0]  pt_in,
  output wire        pad5_in,
  output wire        pe0_in,
  output wire        cmp_in,
  output wire        aclk_in,
  output wire        irq_pin,
  output wire        serial0_receive,
  output wire        serial1_receive
);
  // Pins are always driven, so no released level is modelled
  assign {serial1_receive, serial0_receive, irq_pin, aclk_in, cmp_in, pe0_in, pad5_in,
          pt_in, ps_in, pp_in, tim1_oe, tim1_oc, timer0_oe, timer0_oc, pwm_out} = cfg;
endmodule

// [dv/peripheral_signal_routing_test.sv]
// Directed register-bus tests of the signal routing block
`timescale 1ns/1ps
`include "peripheral_signal_routing_regs.vh"
module peripheral_signal_routing_test;
  logic        ref_clk = 0;
  logic        rst = 1;
  logic        special_mode = 0;
  logic        hsel = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic        irq_service = 0;
  logic [46:0] cfg = {7'b0010000, 8'h3C, 4'hC, 8'h96, 4'b0010, 4'h0, 4'h9, 8'h6C};
  logic [31:0] rdata;
  logic [3:0]  src;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  wire         hreadyout, hresp, adc_trigger, bus_clock_output_en, irq_request;
  wire [31:0]  hrdata;
  wire [7:0]   pwm_out, pp_in, pt_in, pp_out, pp_claim, pt_out, pt_claim;
  wire [5:2]   timer0_oc, timer0_oe, timer0_ic;
  wire [1:0]   tim1_oc, tim1_oe, tim1_ic, pj_out, pj_claim;
  wire [3:0]   ps_in, ps_out, ps_claim;
  wire         pad5_in, pe0_in, cmp_in, aclk_in, irq_pin, serial0_receive, serial1_receive;
  periph_pin_model i_periph_pin_model (.cfg(cfg), .pwm_out(pwm_out), .timer0_oc(timer0_oc),
    .timer0_oe(timer0_oe), .tim1_oc(tim1_oc), .tim1_oe(tim1_oe), .pp_in(pp_in), .ps_in(ps_in),
    .pt_in(pt_in), .pad5_in(pad5_in), .pe0_in(pe0_in), .cmp_in(cmp_in), .aclk_in(aclk_in),
    .irq_pin(irq_pin), .serial0_receive(serial0_receive), .serial1_receive(serial1_receive));
  peripheral_signal_routing i_peripheral_signal_routing (.ref_clk(ref_clk), .rst(rst),
    .ce(1'b1), .special_mode(special_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_out(pwm_out),
    .timer0_oc(timer0_oc), .timer0_oe(timer0_oe), .tim1_oc(tim1_oc), .tim1_oe(tim1_oe),
    .pp_in(pp_in), .ps_in(ps_in), .pt_in(pt_in), .pad5_in(pad5_in), .pe0_in(pe0_in),
    .cmp_in(cmp_in), .aclk_in(aclk_in), .irq_pin(irq_pin), .irq_service(irq_service),
    .serial0_receive(serial0_receive), .serial1_receive(serial1_receive),
    .pp_out(pp_out), .pp_claim(pp_claim), .pj_out(pj_out), .pj_claim(pj_claim),
    .ps_out(ps_out), .ps_claim(ps_claim), .pt_out(pt_out), .pt_claim(pt_claim),
    .timer0_ic(timer0_ic), .tim1_ic(tim1_ic), .adc_trigger(adc_trigger),
    .bus_clock_output_en(bus_clock_output_en), .irq_request(irq_request));
  initial forever #10 ref_clk = ~ref_clk;
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      finish_test;
    end
  end
  task check(input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  task ahb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1;
    haddr <= {i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task wr(input logic [9:0] i, input logic [7:0] d);
    ahb(1'b1, i, d);
  endtask
  task rd(input logic [9:0] i, input logic [31:0] e);
    ahb(1'b0, i, 8'h00);
    check(rdata, e);
  endtask
  // Covers the synchroniser latency plus the registered output
  task settle;
    repeat (6) @(posedge ref_clk);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    settle;
    check({pp_claim, pp_out, pj_claim, pt_claim}, {8'hFF, cfg[7:0], 10'h0});
    check({timer0_ic, tim1_ic, bus_clock_output_en}, {cfg[37:34], cfg[39:38], 1'b1});
    for (int i = 0; i < 9; i++) rd(10'h200 + 10'(i), 0);
    wr(`IDX_TEST, 8'h5A);
    rd(`IDX_TEST, 0);
    wr(`IDX_PWM_ROUTE, 8'hFF);
    wr(`IDX_PWM_ROUTE, 8'h00);
    rd(`IDX_PWM_ROUTE, 32'h0000_00F5);
    settle;
    check({pj_claim, pt_claim[1:0], pp_claim}, 12'hF0A);
    check({pj_out, pt_out[1:0], pp_out[3], pp_out[1]}, {cfg[7], cfg[5], cfg[0], cfg[2], cfg[3], cfg[1]});
    check({ps_claim[1:0], ps_out[1:0]}, {2'b11, cfg[6], cfg[4]});
    wr(`IDX_TMR_ROUTE, 8'hFF);
    rd(`IDX_TMR_ROUTE, 32'h0000_00FC);
    cfg[19:12] <= 8'hFF;
    settle;
    check({ps_out[3:2], pp_out[1], pp_out[7]}, {cfg[11:10], cfg[17:16]});
    check({ps_claim[3:2], pp_claim[7], pp_claim[1], pt_claim[7:2]}, 10'h3C0);
    check({ps_claim[1:0], ps_out[1:0]}, {2'b11, cfg[9:8]});
    check({timer0_ic, tim1_ic}, {cfg[31:28], cfg[21], cfg[27]});
    wr(`IDX_CLK_OUT, 8'hFF);
    rd(`IDX_CLK_OUT, 32'h0000_0080);
    check(bus_clock_output_en, 0);
    wr(`IDX_CLK_OUT, 8'h00);
    settle;
    check(bus_clock_output_en, 1);
    wr(`IDX_IRQ_CTRL, 8'h40);
    cfg[44] <= 0;
    settle;
    check(irq_request, 1);
    wr(`IDX_IRQ_CTRL, 8'hC0);
    rd(`IDX_IRQ_CTRL, 32'h0000_0040);
    wr(`IDX_IRQ_CTRL, 8'h00);
    settle;
    check(irq_request, 0);
    cfg[44] <= 1;
    special_mode <= 1;
    wr(`IDX_TEST, 8'hA5);
    rd(`IDX_TEST, 32'h0000_00A5);
    wr(`IDX_ADC_ROUTE, 8'hFF);
    rd(`IDX_ADC_ROUTE, 32'h0000_000F);
    for (int k = 0; k < 16; k++) begin
      src = k[3] ? 4'h6 : 4'h9;
      {cfg[26], cfg[40], cfg[41], cfg[8]} <= src;
      {cfg[43], cfg[46], cfg[45], cfg[29]} <= src;
      wr(`IDX_ADC_ROUTE, 8'(k[2:0]));
      wr(`IDX_CAP_SEL, 8'(k[1:0]));
      settle;
      check(adc_trigger, src[k[1:0]] ^ k[2]);
      check(timer0_ic[3], src[k[1:0]]);
    end
    cfg[42] <= 1;
    wr(`IDX_ADC_ROUTE, 8'h0C);
    settle;
    check(adc_trigger, 0);
    wr(`IDX_IRQ_CTRL, 8'hC0);
    settle;
    cfg[44] <= 0;
    settle;
    cfg[44] <= 1;
    settle;
    check(irq_request, 1);
    irq_service <= 1;
    @(posedge ref_clk);
    irq_service <= 0;
    settle;
    check(irq_request, 0);
    rst <= 1;
    special_mode <= 0;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    rd(`IDX_PWM_ROUTE, 0);
    wr(`IDX_PWM_ROUTE, 8'h04);
    rd(`IDX_PWM_ROUTE, 32'h0000_0004);
    check({pt_claim[7:2], pt_out[7:2]}, {6'h3F, cfg[17:16], cfg[11:8]});
    finish_test;
  end
endmodule
